//--- suc_if.sv
`timescale 1ns/1ps
interface suc_if;
    logic       sync_mode;
    logic       par_en;
    logic       par_odd;
    logic       msb_first;
    logic [7:0] div;
    logic       tx_clr;
    logic       tx_start;
    logic [7:0] tx_data;
    logic       tx_busy;
    logic       txd;
    logic       sck;
    logic       sck_rise;
    logic       rx_clr;
    logic       rx_on;
    logic       rxd;
    logic       rx_valid;
    logic       rx_perr;
    logic       rx_ferr;
    logic [7:0] rx_data;
    modport core(output sync_mode, par_en, par_odd, msb_first, div, tx_clr, tx_start, tx_data,
                 rx_clr, rx_on, rxd, input tx_busy, txd, sck, rx_valid, rx_perr, rx_ferr, rx_data);
    modport tx(input sync_mode, par_en, par_odd, msb_first, div, tx_clr, tx_start, tx_data,
               output tx_busy, txd, sck, sck_rise);
    modport rx(input sync_mode, par_en, par_odd, msb_first, div, rx_clr, rx_on, rxd, sck_rise,
               output rx_valid, rx_perr, rx_ferr, rx_data);
endinterface

//--- suc_peer.sv
`timescale 1ns/1ps
module suc_peer #(
    parameter int BIT = 8
) (
    input  wire logic pclk,
    input  wire logic txd,
    output logic      rxd
);
    // Line rests at mark between frames
    initial rxd = 1'b1;
    task automatic send_break(input int n);
        @(posedge pclk);
        rxd <= 1'b0;
        repeat (n) @(posedge pclk);
        rxd <= 1'b1;
    endtask
    // Bounded wait so a dead line cannot hang the run
    task automatic get_byte(output logic [7:0] b);
        int n;
        n = 0;
        while (txd !== 1'b0 && n < 2000) begin
            @(posedge pclk);
            n++;
        end
        repeat (BIT / 2) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge pclk);
            b[i] = txd;
        end
    endtask
endmodule

//--- suc_pkg.sv
package suc_pkg;
    localparam logic [7:0] OFS_FORMAT = 8'h00, OFS_BAUD = 8'h04, OFS_CTL = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C, OFS_TXHOLD = 8'h10, OFS_RXHOLD = 8'h14;
    localparam logic [7:0] OFS_BITORD = 8'h18, OFS_PORT = 8'h1C, OFS_MSTOP = 8'h20;
    localparam int FMT_SYNC = 0, FMT_PAR_EN = 1, FMT_PAR_ODD = 2;
    localparam int CTL_TXE_IE = 7, CTL_TX_ON = 5, CTL_RX_ON = 4, CTL_TXD_IE = 2;
    localparam int CTL_CK_HI = 1, CTL_CK_LO = 0;
    localparam int ST_TX_HOLD_EMPTY_FLAG = 7, ST_RDRF = 6, ST_OVERRUN_ERR_FLAG = 5, ST_FER = 4, ST_PER = 3;
    localparam int ST_TEND = 2, ST_RFLT = 1;
    localparam int PT_TXD_DIR = 0, PT_TXD_LVL = 1, PT_SCK_DIR = 2, PT_SCK_LVL = 3;
    localparam int PT_TXD_SENSE = 4, PT_SCK_SENSE = 5, BO_MSB = 0, MS_STOP = 0;
    localparam logic [7:0] FORMAT_RST = 8'h00, BAUD_RST = 8'hFF, CTL_RST = 8'h00;
    localparam logic [7:0] BITORD_RST = 8'h00, HOLD_RST = 8'h00;
    localparam logic [3:0] PORT_RST = 4'h0;
    localparam logic MSTOP_RST = 1'h1;
    localparam logic [3:0] DATA_BITS = 4'h8;
    typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} suc_tx_st_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} suc_rx_st_t;
endpackage

//--- suc_rx.sv
`timescale 1ns/1ps
module suc_rx import suc_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    suc_if.rx        b
);
    suc_rx_st_t st_r;
    logic [8:0] hc_r;
    logic [9:0] sh_r;
    logic [3:0] cnt_r;
    logic       valid_r;
    logic       perr_r;
    logic       ferr_r;
    logic [7:0] data_r;
    logic [3:0] nbits;
    logic       samp;
    logic       last;
    logic [9:0] sh_n;
    logic [7:0] dat;
    logic [7:0] dat_rev;

    assign nbits = b.sync_mode ? DATA_BITS : DATA_BITS + {3'h0, b.par_en} + 4'h1;
    assign samp = b.sync_mode ? b.sck_rise : (hc_r == 9'h000);
    assign sh_n = {b.rxd, sh_r[9:1]};
    assign last = (st_r == RX_BITS) & samp & (cnt_r == 4'h1);
    assign dat = b.sync_mode ? sh_n[9:2] : (b.par_en ? sh_n[7:0] : sh_n[8:1]);
    assign dat_rev = {<<{dat}};
    assign b.rx_valid = valid_r;
    assign b.rx_perr = perr_r;
    assign b.rx_ferr = ferr_r;
    assign b.rx_data = data_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= RX_IDLE;
            hc_r <= 9'h000;
            sh_r <= 10'h000;
            cnt_r <= 4'h0;
            valid_r <= 1'h0;
            perr_r <= 1'h0;
            ferr_r <= 1'h0;
            data_r <= 8'h00;
        end else begin
            valid_r <= last;
            ferr_r <= last & ~b.sync_mode & ~sh_n[9];
            perr_r <= last & ~b.sync_mode & b.par_en & ((^{dat, sh_n[8]}) != b.par_odd);
            if (last) begin
                data_r <= b.msb_first ? dat_rev : dat;
            end
            if (b.rx_clr | ~b.rx_on) begin
                st_r <= RX_IDLE;
            end else begin
                case (st_r)
                    RX_IDLE: begin
                        cnt_r <= nbits;
                        if (b.sync_mode) begin
                            st_r <= RX_BITS;
                        // a held low line restarts at once
                        end else if (!b.rxd) begin
                            st_r <= RX_START;
                            hc_r <= {1'h0, b.div};
                        end
                    end
                    RX_START: begin
                        hc_r <= hc_r - 9'h001;
                        if (hc_r == 9'h000) begin
                            st_r <= b.rxd ? RX_IDLE : RX_BITS;
                            hc_r <= {b.div, 1'h1};
                        end
                    end
                    default: begin
                        hc_r <= (hc_r == 9'h000) ? {b.div, 1'h1} : hc_r - 9'h001;
                        if (samp) begin
                            sh_r <= sh_n;
                            cnt_r <= cnt_r - 4'h1;
                            if (cnt_r == 4'h1) begin
                                st_r <= RX_IDLE;
                            end
                        end
                    end
                endcase
            end
        end
    end
endmodule

//--- suc_top.sv
`timescale 1ns/1ps
module suc_top import suc_pkg::*; (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        standby,
    input  wire logic        rxd,
    input  wire logic        txd_sense,
    output logic             txd,
    output logic             txd_oe,
    input  wire logic        sck_sense,
    output logic             sck,
    output logic             sck_oe
);
    suc_if b();

    logic [7:0]  fmt_r;
    logic [7:0]  baud_r;
    logic [7:0]  ctl_r;
    logic [7:0]  bitord_r;
    logic [3:0]  port_r;
    logic        mstop_r;
    logic [7:0]  tx_hold_r;
    logic [7:0]  rx_hold_r;
    logic        tx_hold_empty_flag_r;
    logic        rdrf_r;
    logic        overrun_err_flag_r;
    logic        fer_r;
    logic        per_r;
    logic        rflt_r;
    logic        tend_r;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic        txd_r;
    logic        txd_oe_r;
    logic        sck_r;
    logic        sck_oe_r;
    logic [8:0]  pulse_r;

    logic        setup;
    logic        acc;
    logic        wr;
    logic        hit_fmt;
    logic        hit_baud;
    logic        hit_ctl;
    logic        hit_st;
    logic        hit_txh;
    logic        hit_rxh;
    logic        hit_bo;
    logic        hit_port;
    logic        hit_ms;
    logic        mapped;
    logic        blocked;
    logic        wr_ok;
    logic        lp;
    logic        tx_on;
    logic        rx_on;
    logic        sync;
    logic        ck_hi;
    logic        rx_err;
    logic        start;
    logic        st_clr_wr;
    logic        rx_store;
    logic        sck_int;
    logic        pulse_act;
    logic        trig;
    logic [7:0]  st_v;
    logic [7:0]  pt_v;
    logic [7:0]  rd_byte;
    logic        tx_hold_empty_flag_nxt;
    logic        rdrf_nxt;
    logic        overrun_err_flag_nxt;
    logic        fer_nxt;
    logic        per_nxt;
    logic        rflt_nxt;
    logic        txd_nxt;
    logic        txd_oe_nxt;
    logic        sck_nxt;
    logic        sck_oe_nxt;
    logic [8:0]  pulse_nxt;

    // Zero-wait slave: pready rises in the access cycle
    assign setup = psel & ~penable;
    assign acc = psel & penable & pready_r;
    assign hit_fmt = (paddr == {4'h0, OFS_FORMAT});
    assign hit_baud = (paddr == {4'h0, OFS_BAUD});
    assign hit_ctl = (paddr == {4'h0, OFS_CTL});
    assign hit_st = (paddr == {4'h0, OFS_STATUS});
    assign hit_txh = (paddr == {4'h0, OFS_TXHOLD});
    assign hit_rxh = (paddr == {4'h0, OFS_RXHOLD});
    assign hit_bo = (paddr == {4'h0, OFS_BITORD});
    assign hit_port = (paddr == {4'h0, OFS_PORT});
    assign hit_ms = (paddr == {4'h0, OFS_MSTOP});
    assign mapped = hit_fmt | hit_baud | hit_ctl | hit_st | hit_txh | hit_rxh | hit_bo
                  | hit_port | hit_ms;
    // only the stop register is reachable while stopped
    assign blocked = mstop_r & ~hit_ms;
    assign wr = acc & pwrite;
    assign wr_ok = wr & mapped & ~blocked;

    assign lp = mstop_r | standby;
    assign tx_on = ctl_r[CTL_TX_ON];
    assign rx_on = ctl_r[CTL_RX_ON];
    assign sync = fmt_r[FMT_SYNC];
    assign ck_hi = ctl_r[CTL_CK_HI];
    assign rx_err = overrun_err_flag_r | fer_r | rflt_r;
    // synchronous transmit waits for clean overrun, framing and break flags
    assign start = tx_on & ~lp & ~tx_hold_empty_flag_r & ~b.tx_busy & ~(sync & rx_err);
    assign st_clr_wr = wr_ok & hit_st;
    assign rx_store = b.rx_valid & ~rdrf_r;

    assign st_v = {tx_hold_empty_flag_r, rdrf_r, overrun_err_flag_r, fer_r, per_r, tend_r, rflt_r, 1'h0};
    assign pt_v = {2'h0, sck_sense, txd_sense, port_r};
    assign rd_byte = blocked ? 8'h00
                   : hit_fmt ? fmt_r
                   : hit_baud ? baud_r
                   : hit_ctl ? ctl_r
                   : hit_st ? st_v
                   : hit_txh ? tx_hold_r
                   : hit_rxh ? rx_hold_r
                   : hit_bo ? bitord_r
                   : hit_port ? pt_v
                   : hit_ms ? {7'h00, mstop_r}
                   : 8'h00;

    // low power resets status; hardware sets win over software clears
    assign tx_hold_empty_flag_nxt = lp | start | (tx_hold_empty_flag_r & ~(st_clr_wr & ~pwdata[ST_TX_HOLD_EMPTY_FLAG]));
    assign rdrf_nxt = ~lp & (rx_store | (rdrf_r & ~(st_clr_wr & ~pwdata[ST_RDRF])));
    assign overrun_err_flag_nxt = ~lp & ((b.rx_valid & rdrf_r) | (overrun_err_flag_r & ~(st_clr_wr & ~pwdata[ST_OVERRUN_ERR_FLAG])));
    // a repeated break frame re-sets the flag
    assign fer_nxt = ~lp & ((b.rx_valid & b.rx_ferr) | (fer_r & ~(st_clr_wr & ~pwdata[ST_FER])));
    // parity may flag on a break as well
    assign per_nxt = ~lp & ((b.rx_valid & b.rx_perr) | (per_r & ~(st_clr_wr & ~pwdata[ST_PER])));
    assign rflt_nxt = ~lp & ((b.rx_valid & b.rx_ferr & (b.rx_data == 8'h00))
                    | (rflt_r & ~(st_clr_wr & ~pwdata[ST_RFLT])));

    // disabled transmitter leaves the pin to port settings
    assign txd_nxt = tx_on ? b.txd : port_r[PT_TXD_LVL];
    assign txd_oe_nxt = tx_on | port_r[PT_TXD_DIR];
    // Upper clock function set means an outside clock, so the pin is left to port settings
    assign sck_int = sync & ~ck_hi;
    assign pulse_act = (pulse_r != 9'h000);
    // leaving synchronous select with our clock on the pin
    assign trig = wr_ok & hit_fmt & sync & ~pwdata[FMT_SYNC] & ~ck_hi;
    assign pulse_nxt = trig ? {1'h0, baud_r} + 9'h001 : (pulse_act ? pulse_r - 9'h001 : 9'h000);
    assign sck_nxt = pulse_act ? 1'h0 : (sck_int ? b.sck : port_r[PT_SCK_LVL]);
    assign sck_oe_nxt = pulse_act | sck_int | port_r[PT_SCK_DIR];

    assign b.sync_mode = sync;
    assign b.par_en = fmt_r[FMT_PAR_EN];
    assign b.par_odd = fmt_r[FMT_PAR_ODD];
    assign b.msb_first = bitord_r[BO_MSB];
    assign b.div = baud_r;
    // clearing transmit enable resets the shifter at once
    assign b.tx_clr = ~tx_on | lp;
    assign b.tx_start = start;
    assign b.tx_data = tx_hold_r;
    assign b.rx_clr = lp;
    assign b.rx_on = rx_on;
    assign b.rxd = rxd;

    suc_tx u_tx (
        .pclk    (pclk),
        .presetn (presetn),
        .b       (b.tx)
    );

    suc_rx u_rx (
        .pclk    (pclk),
        .presetn (presetn),
        .b       (b.rx)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'h0;
            pslverr_r <= 1'h0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= setup;
            pslverr_r <= setup & (~mapped | blocked);
            prdata_r <= (setup & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mstop_r <= MSTOP_RST;
        end else if (wr_ok & hit_ms) begin
            mstop_r <= pwdata[MS_STOP];
        end
    end

    // Config writes are taken even when enabled; the unit does not police them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fmt_r <= FORMAT_RST;
            baud_r <= BAUD_RST;
            ctl_r <= CTL_RST;
            bitord_r <= BITORD_RST;
            port_r <= PORT_RST;
        end else begin
            if (wr_ok & hit_fmt) begin
                fmt_r <= pwdata[7:0];
            end
            if (wr_ok & hit_baud) begin
                baud_r <= pwdata[7:0];
            end
            // clearing receive enable touches no flag
            if (wr_ok & hit_ctl) begin
                ctl_r <= pwdata[7:0];
            end
            if (wr_ok & hit_bo) begin
                bitord_r <= pwdata[7:0];
            end
            if (wr_ok & hit_port) begin
                port_r <= pwdata[3:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_hold_r <= HOLD_RST;
            rx_hold_r <= HOLD_RST;
        end else if (lp) begin
            tx_hold_r <= HOLD_RST;
            rx_hold_r <= HOLD_RST;
        end else begin
            // overwrite allowed; unsent byte is lost
            if (wr_ok & hit_txh) begin
                tx_hold_r <= pwdata[7:0];
            end
            if (rx_store) begin
                rx_hold_r <= b.rx_data;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_hold_empty_flag_r <= 1'h1;
            rdrf_r <= 1'h0;
            overrun_err_flag_r <= 1'h0;
            fer_r <= 1'h0;
            per_r <= 1'h0;
            rflt_r <= 1'h0;
            tend_r <= 1'h1;
        end else begin
            tx_hold_empty_flag_r <= tx_hold_empty_flag_nxt;
            rdrf_r <= rdrf_nxt;
            overrun_err_flag_r <= overrun_err_flag_nxt;
            fer_r <= fer_nxt;
            per_r <= per_nxt;
            rflt_r <= rflt_nxt;
            tend_r <= tx_hold_empty_flag_nxt & ~b.tx_busy & ~start;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txd_r <= 1'h1;
            txd_oe_r <= 1'h0;
            sck_r <= 1'h1;
            sck_oe_r <= 1'h0;
            pulse_r <= 9'h000;
        end else begin
            txd_r <= txd_nxt;
            txd_oe_r <= txd_oe_nxt;
            sck_r <= sck_nxt;
            sck_oe_r <= sck_oe_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign txd = txd_r;
    assign txd_oe = txd_oe_r;
    assign sck = sck_r;
    assign sck_oe = sck_oe_r;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_mstop_blocks_wr: assert property (
        (wr & mstop_r & ~hit_ms) |=> $stable(ctl_r) && $stable(fmt_r) && $stable(tx_hold_r))
        else $error("write reached a register while stopped");
    a_mstop_err_resp: assert property (
        (setup & mstop_r & ~hit_ms) |=> pslverr && pready && (prdata == 32'h0000_0000))
        else $error("stopped access not refused");
    a_fer_on_break: assert property (
        (b.rx_valid & b.rx_ferr & ~lp) |=> fer_r)
        else $error("framing flag missed on bad stop bit");
    a_fer_set_wins: assert property (
        (b.rx_valid & b.rx_ferr & ~lp & st_clr_wr & ~pwdata[ST_FER]) |=> fer_r)
        else $error("clear beat a framing set");
    a_txd_port_follow: assert property (
        (presetn && !tx_on) |=> (txd == $past(port_r[PT_TXD_LVL]))
        && (txd_oe == $past(port_r[PT_TXD_DIR])))
        else $error("disabled output not following port");
    a_sync_err_block: assert property (
        (sync & rx_err) |-> !b.tx_start)
        else $error("synchronous transmit started with error set");
    a_err_kept: assert property (
        (wr_ok & hit_ctl & rx_on & ~pwdata[CTL_RX_ON] & overrun_err_flag_r & ~lp) |=> overrun_err_flag_r)
        else $error("receive disable cleared overrun");
    a_hold_overwrite: assert property (
        (wr_ok & hit_txh & ~lp) |=> tx_hold_r == $past(pwdata[7:0]))
        else $error("holding buffer write not taken");
    a_lp_reset: assert property (
        lp |=> tx_hold_empty_flag_r && !rdrf_r && !overrun_err_flag_r && !fer_r && !b.tx_busy)
        else $error("low power did not reset the unit");
    a_idle_mark: assert property (
        (tx_on & ~b.tx_busy) |=> txd && txd_oe)
        else $error("enabled idle output not at mark");
    a_sck_low_pulse: assert property (
        trig |=> ##1 (!sck && sck_oe) [*2])
        else $error("clock pin handover pulse missing");
endmodule

//--- suc_tx.sv
`timescale 1ns/1ps
module suc_tx import suc_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    suc_if.tx        b
);
    suc_tx_st_t  st_r;
    logic [7:0]  hc_r;
    logic        ph_r;
    logic        rise_r;
    logic [10:0] sh_r;
    logic [3:0]  cnt_r;
    logic [7:0]  d;
    logic [7:0]  d_rev;
    logic [10:0] frame;
    logic [3:0]  nbits;
    logic        hend;

    assign d_rev = {<<{b.tx_data}};
    assign d = b.msb_first ? d_rev : b.tx_data;
    assign frame = b.sync_mode ? {3'h7, d}
                 : (b.par_en ? {1'h1, ^d ^ b.par_odd, d, 1'h0} : {2'h3, d, 1'h0});
    assign nbits = b.sync_mode ? DATA_BITS : DATA_BITS + {3'h0, b.par_en} + 4'h2;
    assign hend = (hc_r == 8'h00);
    assign b.tx_busy = (st_r == TX_SHIFT);
    assign b.txd = b.tx_busy ? sh_r[0] : 1'h1;
    // Clock idles high; low in the first half of each bit
    assign b.sck = (b.tx_busy & b.sync_mode) ? ph_r : 1'h1;
    assign b.sck_rise = rise_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= TX_IDLE;
            hc_r <= 8'h00;
            ph_r <= 1'h0;
            rise_r <= 1'h0;
            sh_r <= 11'h7FF;
            cnt_r <= 4'h0;
        end else if (b.tx_clr) begin
            st_r <= TX_IDLE;
            hc_r <= 8'h00;
            ph_r <= 1'h0;
            rise_r <= 1'h0;
            sh_r <= 11'h7FF;
            cnt_r <= 4'h0;
        end else begin
            rise_r <= 1'h0;
            case (st_r)
                TX_IDLE: begin
                    if (b.tx_start) begin
                        st_r <= TX_SHIFT;
                        sh_r <= frame;
                        cnt_r <= nbits;
                        hc_r <= b.div;
                        ph_r <= 1'h0;
                    end
                end
                default: begin
                    hc_r <= hend ? b.div : hc_r - 8'h01;
                    if (hend) begin
                        ph_r <= ~ph_r;
                        rise_r <= ~ph_r & b.sync_mode;
                    end
                    if (hend & ph_r) begin
                        sh_r <= {1'h1, sh_r[10:1]};
                        cnt_r <= cnt_r - 4'h1;
                        if (cnt_r == 4'h1) begin
                            st_r <= TX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    a_tx_clear_init: assert property (@(posedge pclk) disable iff (!presetn)
        b.tx_clr |=> !b.tx_busy && b.txd) else $error("transmitter not reset by clear");
endmodule

//--- uart_tx_rx_control_tb_top.sv
`timescale 1ns/1ps
module uart_tx_rx_control_tb_top import suc_pkg::*;;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, standby = 1'b0, e;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [7:0]  q, b1, b2;
    wire  [31:0] prdata;
    wire         pready, pslverr, rxd, txd, txd_oe, sck, sck_oe;
    int          n_errors = 0, tests_run = 0;
    always #10 pclk = ~pclk;
    suc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .standby(standby), .rxd(rxd), .txd_sense(txd_oe ? txd : 1'b1),
        .txd(txd), .txd_oe(txd_oe), .sck_sense(sck_oe ? sck : 1'b1), .sck(sck),
        .sck_oe(sck_oe));
    suc_peer #(.BIT(8)) i_peer (.pclk(pclk), .txd(txd), .rxd(rxd));
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, 4'h0, a, 24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata[7:0];
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
        tests_run++;
        if (got !== ex) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic tally_and_finish();
        if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic sc_stop();
        wr(OFS_CTL, 8'h30);
        chk("wr_refused", 8'h01, {7'h0, e});
        apb(1'b0, OFS_CTL, 8'h00);
        chk("slverr_stopped", 8'h01, {7'h0, e});
        wr(OFS_MSTOP, 8'h00);
        apb(1'b0, OFS_CTL, 8'h00);
        chk("ctl_kept", 8'h00, q);
        wr(OFS_BAUD, 8'h03);
        apb(1'b0, OFS_STATUS, 8'h00);
        chk("status_reset", 8'h84, q);
    endtask
    task automatic sc_tx();
        wr(OFS_PORT, 8'h03);
        wr(OFS_CTL, 8'h20);
        cyc(2);
        chk("txd_idle", 8'h01, {7'h0, txd});
        wr(OFS_TXHOLD, 8'hA5);
        wr(OFS_STATUS, 8'h7F);
        fork
            i_peer.get_byte(b1);
            begin
                cyc(24);
                wr(OFS_TXHOLD, 8'h3C);
                wr(OFS_STATUS, 8'h7F);
                wr(OFS_TXHOLD, 8'h5A);
            end
        join
        i_peer.get_byte(b2);
        chk("frame1", 8'hA5, b1);
        chk("frame2", 8'h5A, b2);
    endtask
    task automatic sc_brk_tx();
        wr(OFS_PORT, 8'h01);
        wr(OFS_TXHOLD, 8'hFF);
        wr(OFS_STATUS, 8'h7F);
        cyc(30);
        wr(OFS_CTL, 8'h00);
        cyc(2);
        chk("txd_break", 8'h02, {6'h0, txd_oe, txd});
        wr(OFS_PORT, 8'h03);
        cyc(2);
        chk("txd_mark", 8'h03, {6'h0, txd_oe, txd});
    endtask
    task automatic sc_brk_rx();
        wr(OFS_CTL, 8'h10);
        fork
            i_peer.send_break(320);
            begin
                cyc(150);
                apb(1'b0, OFS_STATUS, 8'h00);
                chk("fer_break", 8'h01, {7'h0, q[ST_FER]});
                wr(OFS_STATUS, 8'hEF);
                cyc(150);
                apb(1'b0, OFS_STATUS, 8'h00);
                chk("fer_again", 8'h01, {7'h0, q[ST_FER]});
            end
        join
        wr(OFS_CTL, 8'h00);
        apb(1'b0, OFS_STATUS, 8'h00);
        chk("fer_kept", 8'h01, {7'h0, q[ST_FER]});
    endtask
    task automatic sc_sync();
        wr(OFS_FORMAT, 8'h01);
        wr(OFS_CTL, 8'h20);
        wr(OFS_TXHOLD, 8'h55);
        wr(OFS_STATUS, 8'h7F);
        cyc(20);
        apb(1'b0, OFS_STATUS, 8'h00);
        chk("tx_blocked", 8'h00, {7'h0, q[ST_TX_HOLD_EMPTY_FLAG]});
        wr(OFS_STATUS, 8'h00);
        cyc(8);
        apb(1'b0, OFS_STATUS, 8'h00);
        chk("tx_started", 8'h01, {7'h0, q[ST_TX_HOLD_EMPTY_FLAG]});
        cyc(90);
        wr(OFS_CTL, 8'h00);
        wr(OFS_FORMAT, 8'h00);
        cyc(3);
        #1;
        chk("sck_pulse", 8'h02, {6'h0, sck_oe, sck});
        wr(OFS_PORT, 8'h0F);
        wr(OFS_FORMAT, 8'h01);
        wr(OFS_CTL, 8'h02);
        wr(OFS_FORMAT, 8'h00);
        cyc(2);
        chk("sck_no_pulse", 8'h03, {6'h0, sck_oe, sck});
        wr(OFS_CTL, 8'h00);
    endtask
    task automatic sc_power();
        wr(OFS_PORT, 8'h01);
        wr(OFS_CTL, 8'h20);
        wr(OFS_TXHOLD, 8'h77);
        wr(OFS_STATUS, 8'h7F);
        wr(OFS_TXHOLD, 8'h66);
        wr(OFS_STATUS, 8'h7F);
        wr(OFS_CTL, 8'h00);
        standby <= 1'b1;
        cyc(4);
        standby <= 1'b0;
        apb(1'b0, OFS_STATUS, 8'h00);
        chk("status_lowpwr", 8'h84, q);
        chk("txd_port", 8'h02, {6'h0, txd_oe, txd});
        wr(OFS_BITORD, 8'h01);
        wr(OFS_CTL, 8'h30);
        cyc(2);
        chk("txd_resume", 8'h01, {7'h0, txd});
        apb(1'b0, OFS_STATUS, 8'h00);
        chk("tx_hold_empty_flag_resume", 8'h01, {7'h0, q[ST_TX_HOLD_EMPTY_FLAG]});
        wr(OFS_TXHOLD, 8'h1E);
        wr(OFS_STATUS, 8'h7F);
        i_peer.get_byte(b1);
        chk("frame_msb", 8'h78, b1);
    endtask
    initial begin
        cyc(6);
        presetn <= 1'b1;
        sc_stop();
        sc_tx();
        sc_brk_tx();
        sc_brk_rx();
        sc_sync();
        sc_power();
        tally_and_finish();
    end
    initial begin
        cyc(20000);
        n_errors++;
        tally_and_finish();
    end
endmodule
